// >>> dpd_consts.svh
// Constants for the dual port converter clock and decode block
`ifndef DPD_CONSTS_SVH
`define DPD_CONSTS_SVH
`define DPD_WORD_W 10
`define DPD_UPPER_W 5
`define DPD_MID_W 4
`define DPD_UPPER_SEG 31
`define DPD_MID_SEG 15
`define DPD_PERIOD_W 16
`define DPD_LOCK_CNT 4'h8
`define DPD_PERIOD_TOL 16'h0001
`define DPD_SYNC_W 24
`define DPD_SYNC_EXT 23
`define DPD_SYNC_SUP 22
`define DPD_SYNC_SHI 21
`define DPD_SYNC_SLO 20
`endif

// >>> dpd_pkg.sv
// Types shared by the dual port converter clock and decode block
package dpd_pkg;
    typedef struct packed {
        logic [30:0] upper;
        logic [14:0] mid;
        logic lsb;
    } dpd_seg_s;
    typedef struct packed {
        logic [9:0] first_port_bits;
        logic [9:0] second_port_bits;
    } dpd_ports_s;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ACQ,
        ST_LOCKED
    } dpd_lock_e;
endpackage

// >>> dpd_core.sv
// Clock doubling, port interleave and segment decode for the converter
`timescale 1ns/10ps
`include "dpd_consts.svh"
module dpd_core (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_ext_clk,
    input wire logic i_multiplier_supply_pin,
    input wire logic i_range_sel_hi,
    input wire logic i_range_sel_lo,
    input wire dpd_pkg::dpd_ports_s i_ports,
    output logic o_lock_indicator,
    output logic o_x2_tick,
    output logic [3:0] o_range_div,
    output logic [9:0] o_dac_word,
    output dpd_pkg::dpd_seg_s o_current_out_true,
    output dpd_pkg::dpd_seg_s o_current_out_comp
);
    import dpd_pkg::*;

    localparam int PW = `DPD_PERIOD_W;

    function automatic logic [30:0] therm31(input logic [4:0] v);
        logic [30:0] t;
        t = '0;
        for (int k = 0; k < `DPD_UPPER_SEG; k++) begin
            t[k] = (5'(k) < v);
        end
        return t;
    endfunction

    function automatic logic [14:0] therm15(input logic [3:0] v);
        logic [14:0] t;
        t = '0;
        for (int k = 0; k < `DPD_MID_SEG; k++) begin
            t[k] = (4'(k) < v);
        end
        return t;
    endfunction

    // Pin synchronisers: a bit changes once stages two and three agree
    logic [`DPD_SYNC_W-1:0] raw;
    logic [`DPD_SYNC_W-1:0] s1_q, s2_q, s3_q, sv_q, sv_d;
    assign raw = {i_ext_clk, i_multiplier_supply_pin, i_range_sel_hi,
                  i_range_sel_lo, i_ports};

    genvar gi;
    generate
        for (gi = 0; gi < `DPD_SYNC_W; gi++) begin : g_sync
            always_comb begin
                sv_d[gi] = (s2_q[gi] == s3_q[gi]) ? s3_q[gi] : sv_q[gi];
            end
        end
    endgenerate

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            sv_q <= '0;
        end else begin
            s1_q <= raw;
            s2_q <= s1_q;
            s3_q <= s2_q;
            sv_q <= sv_d;
        end
    end

    dpd_ports_s pin_ports;
    logic active;
    logic [1:0] sel;
    assign pin_ports = dpd_ports_s'(sv_q[19:0]);
    assign active = sv_q[`DPD_SYNC_SUP];
    assign sel = {sv_q[`DPD_SYNC_SHI], sv_q[`DPD_SYNC_SLO]};

    // Clock recovery: period measure, prescaled sub ticks, mid-period tick
    logic ext_prev_q, rise;
    logic [PW-1:0] cnt_q, cnt_d, period_q, period_d, prev_q, prev_d;
    logic [PW-1:0] sub_len, sub_cnt_q, sub_cnt_d;
    logic [3:0] presc_q, presc_d, div;
    logic mid, mid_done_q, mid_done_d, fb_q, fb_d;
    logic [3:0] good_q, good_d;
    dpd_lock_e st_q, st_d;
    logic period_ok;

    assign rise = active & sv_q[`DPD_SYNC_EXT] & ~ext_prev_q;
    assign div = 4'h1 << sel;
    assign period_ok = (period_d >= prev_q ? period_d - prev_q
                                           : prev_q - period_d)
                       <= `DPD_PERIOD_TOL;

    always_comb begin
        // Each sub tick spans period/(2*div), so div of them reach mid-period
        sub_len = period_q >> ({1'b0, sel} + 3'h1);
        if (sub_len == '0) begin
            sub_len = PW'(1);
        end
    end

    always_comb begin
        cnt_d = cnt_q + PW'(1);
        period_d = period_q;
        prev_d = prev_q;
        sub_cnt_d = sub_cnt_q;
        presc_d = presc_q;
        mid_done_d = mid_done_q;
        fb_d = fb_q;
        good_d = good_q;
        st_d = st_q;
        mid = 1'b0;
        if (!active) begin
            cnt_d = '0;
            sub_cnt_d = '0;
            presc_d = '0;
            mid_done_d = 1'b0;
            fb_d = 1'b0;
            good_d = '0;
            st_d = ST_IDLE;
        end else if (rise) begin
            period_d = cnt_q + PW'(1);
            prev_d = period_q;
            cnt_d = '0;
            sub_cnt_d = '0;
            presc_d = '0;
            mid_done_d = 1'b0;
            fb_d = ~fb_q;
            // Phase check: the halved feedback must have toggled at mid
            case (st_q)
                ST_IDLE: begin
                    st_d = ST_ACQ;
                    good_d = '0;
                end
                ST_ACQ: begin
                    if (mid_done_q && fb_q == 1'b0 && period_ok) begin
                        good_d = good_q + 4'h1;
                        if (good_q + 4'h1 >= `DPD_LOCK_CNT) begin
                            st_d = ST_LOCKED;
                        end
                    end else begin
                        good_d = '0;
                    end
                end
                ST_LOCKED: begin
                    if (!(mid_done_q && fb_q == 1'b0 && period_ok)) begin
                        st_d = ST_ACQ;
                        good_d = '0;
                    end
                end
                default: begin
                    st_d = ST_IDLE;
                end
            endcase
        end else if (!mid_done_q && period_q != '0) begin
            if (sub_cnt_q + PW'(1) >= sub_len) begin
                sub_cnt_d = '0;
                presc_d = presc_q + 4'h1;
                if (presc_q + 4'h1 >= div) begin
                    mid = 1'b1;
                    mid_done_d = 1'b1;
                    fb_d = ~fb_q;
                end
            end else begin
                sub_cnt_d = sub_cnt_q + PW'(1);
            end
        end
        if (cnt_q == {PW{1'b1}} && active && !rise) begin
            cnt_d = cnt_q;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ext_prev_q <= 1'b0;
            cnt_q <= '0;
            period_q <= '0;
            prev_q <= '0;
            sub_cnt_q <= '0;
            presc_q <= '0;
            mid_done_q <= 1'b0;
            fb_q <= 1'b0;
            good_q <= '0;
            st_q <= ST_IDLE;
        end else begin
            ext_prev_q <= sv_q[`DPD_SYNC_EXT];
            cnt_q <= cnt_d;
            period_q <= period_d;
            prev_q <= prev_d;
            sub_cnt_q <= sub_cnt_d;
            presc_q <= presc_d;
            mid_done_q <= mid_done_d;
            fb_q <= fb_d;
            good_q <= good_d;
            st_q <= st_d;
        end
    end

    // Data path: port latches, interleave into output latch, decode
    dpd_ports_s lat_q, lat_d;
    logic [9:0] dac_q, dac_d;
    dpd_seg_s seg_q, seg_d;
    logic lock_q, lock_d, x2_q, x2_d;
    logic [3:0] div_q;

    always_comb begin
        lat_d = lat_q;
        dac_d = dac_q;
        if (rise) begin
            lat_d = pin_ports;
            dac_d = lat_q.second_port_bits;
        end else if (mid) begin
            dac_d = lat_q.first_port_bits;
        end
        // Straight binary: top five bits, middle four, then the last bit
        seg_d.upper = therm31(dac_d[9:5]);
        seg_d.mid = therm15(dac_d[4:1]);
        seg_d.lsb = dac_d[0];
        x2_d = rise | mid;
        lock_d = active && st_d == ST_LOCKED;
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            lat_q <= '0;
            dac_q <= '0;
            seg_q <= '0;
            lock_q <= 1'b0;
            x2_q <= 1'b0;
            div_q <= 4'h1;
        end else begin
            lat_q <= lat_d;
            dac_q <= dac_d;
            seg_q <= seg_d;
            lock_q <= lock_d;
            x2_q <= x2_d;
            div_q <= div;
        end
    end

    assign o_dac_word = dac_q;
    assign o_current_out_true = seg_q;
    assign o_current_out_comp = ~seg_q;
    assign o_lock_indicator = lock_q;
    assign o_x2_tick = x2_q;
    assign o_range_div = div_q;

    a_port_capture: assert property (@(posedge i_clk)
        disable iff (!i_rst_n) rise |=> lat_q == $past(pin_ports))
        else $error("ports not captured on rise");
    a_second_out: assert property (@(posedge i_clk)
        disable iff (!i_rst_n) rise |=> dac_q == $past(lat_q.second_port_bits))
        else $error("second port not sent on rise");
    a_first_out: assert property (@(posedge i_clk)
        disable iff (!i_rst_n)
        mid |=> dac_q == $past(lat_q.first_port_bits) ##1 !o_x2_tick)
        else $error("first port not sent at mid");
    a_comp_pair: assert property (@(posedge i_clk)
        disable iff (!i_rst_n) (o_current_out_true ^ o_current_out_comp) == '1)
        else $error("switch pair not complementary");
    a_upper_therm: assert property (@(posedge i_clk)
        disable iff (!i_rst_n)
        $countones(o_current_out_true.upper) == int'(o_dac_word[9:5]))
        else $error("upper segment count wrong");
    a_mid_therm: assert property (@(posedge i_clk)
        disable iff (!i_rst_n)
        $countones(o_current_out_true.mid) == int'(o_dac_word[4:1]))
        else $error("middle segment count wrong");
    a_lsb_pass: assert property (@(posedge i_clk)
        disable iff (!i_rst_n) o_current_out_true.lsb == o_dac_word[0])
        else $error("lsb not passed");
    a_lock_off: assert property (@(posedge i_clk)
        disable iff (!i_rst_n) !active |=> !o_lock_indicator)
        else $error("lock high without supply");
    a_range_div: assert property (@(posedge i_clk)
        disable iff (!i_rst_n) ##1 o_range_div == (4'h1 << $past(sel)))
        else $error("range divide wrong");
    a_x2_tick: assert property (@(posedge i_clk)
        disable iff (!i_rst_n) (rise || mid) |=> o_x2_tick)
        else $error("doubled tick missing");
    a_fb_toggle: assert property (@(posedge i_clk)
        disable iff (!i_rst_n) rise |=> fb_q != $past(fb_q))
        else $error("feedback did not toggle on rise");
    a_latch_hold: assert property (@(posedge i_clk)
        disable iff (!i_rst_n) !rise |=> $stable(lat_q))
        else $error("port latch moved without a rise");
    a_dac_hold: assert property (@(posedge i_clk)
        disable iff (!i_rst_n) !(rise || mid) |=> $stable(o_dac_word))
        else $error("output latch moved without an event");
    a_lock_state: assert property (@(posedge i_clk)
        disable iff (!i_rst_n) o_lock_indicator |-> st_q == ST_LOCKED)
        else $error("lock high outside locked state");
    a_lock_count: assert property (@(posedge i_clk)
        disable iff (!i_rst_n)
        $rose(o_lock_indicator) |-> $past(good_q) == `DPD_LOCK_CNT - 4'h1)
        else $error("lock rose before enough good periods");
    a_upper_shape: assert property (@(posedge i_clk)
        disable iff (!i_rst_n)
        (o_current_out_true.upper & (o_current_out_true.upper + 31'h1)) == '0)
        else $error("upper controls not a thermometer");
    a_mid_shape: assert property (@(posedge i_clk)
        disable iff (!i_rst_n)
        (o_current_out_true.mid & (o_current_out_true.mid + 15'h1)) == '0)
        else $error("middle controls not a thermometer");
    a_div_onehot: assert property (@(posedge i_clk)
        disable iff (!i_rst_n) $onehot(o_range_div))
        else $error("range divide not a power of two");
    a_idle_quiet: assert property (@(posedge i_clk)
        disable iff (!i_rst_n) !active |=> !o_x2_tick)
        else $error("tick without supply");
    a_tick_source: assert property (@(posedge i_clk)
        disable iff (!i_rst_n) o_x2_tick |-> $past(rise || mid))
        else $error("tick without an output latch update");
    a_msb_upper: assert property (@(posedge i_clk)
        disable iff (!i_rst_n) o_dac_word[9] |-> o_current_out_true.upper[15])
        else $error("top bit does not feed upper segments");
endmodule

// >>> dpd_host_model.sv
// Host logic model driving the external clock and both data ports
`timescale 1ns/10ps
module dpd_host_model #(
    parameter int HALF_NS = 203
) (
    input wire logic i_run,
    output logic o_ext_clk,
    output dpd_pkg::dpd_ports_s o_ports
);
    import dpd_pkg::*;
    logic [9:0] idx;
    // Divider reset line is not modelled, so it stays low
    initial begin
        o_ext_clk = 1'b0;
        idx = 10'h000;
        o_ports.first_port_bits = 10'h000;
        o_ports.second_port_bits = 10'h3ff;
    end
    // Clock stands low between bursts, like a gated host clock
    always begin
        #(HALF_NS);
        if (i_run || o_ext_clk) begin
            o_ext_clk = ~o_ext_clk;
        end
    end
    // Words move on the falling edge so every rise sees settled data
    always @(negedge o_ext_clk) begin
        idx = idx + 10'h001;
        o_ports.first_port_bits = idx * 10'h025;
        o_ports.second_port_bits = 10'h3ff - idx * 10'h025;
    end
endmodule

// >>> tb_dual_port_dac_clock_decode.sv
// Self-checking bench for the converter clock and decode block
`timescale 1ns/10ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_count++; \
    $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module tb_dual_port_dac_clock_decode;
    import dpd_pkg::*;
    logic i_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic run = 1'b0;
    logic sup = 1'b0;
    // Select rests at 00 to suit the scaled host clock
    logic shi = 1'b0;
    logic slo = 1'b0;
    logic ext_clk;
    logic lock;
    logic tick;
    logic [3:0] rdiv;
    logic [9:0] word;
    dpd_ports_s ports;
    dpd_ports_s cur;
    dpd_ports_s prev;
    dpd_seg_s seg_t;
    dpd_seg_s seg_c;
    int err_count = 0;
    int n_checks = 0;
    int cyc = 0;
    int nticks = 0;
    int k;
    bit chk_en = 0;
    time t_rise = 0;

    always #10 i_clk = ~i_clk;

    dpd_host_model host_u (.i_run(run), .o_ext_clk(ext_clk), .o_ports(ports));

    dpd_core dut_u (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_ext_clk(ext_clk),
        .i_multiplier_supply_pin(sup), .i_range_sel_hi(shi),
        .i_range_sel_lo(slo), .i_ports(ports), .o_lock_indicator(lock),
        .o_x2_tick(tick), .o_range_div(rdiv), .o_dac_word(word),
        .o_current_out_true(seg_t), .o_current_out_comp(seg_c)
    );

    function automatic dpd_seg_s seg_of(logic [9:0] w);
        dpd_seg_s s;
        for (int i = 0; i < 31; i++) s.upper[i] = (w[9:5] > i);
        for (int i = 0; i < 15; i++) s.mid[i] = (w[4:1] > i);
        s.lsb = w[0];
        return s;
    endfunction

    task automatic wrap_up();
        if (err_count == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic step(int n);
        repeat (n) @(posedge i_clk);
        #2;
    endtask

    // Record what the device should have latched at each host rise
    always @(posedge ext_clk) begin
        prev = cur;
        cur = ports;
        t_rise = $time;
    end

    // Early ticks follow a rise, late ones fall at the half period
    always @(negedge i_clk) begin
        if (tick === 1'b1) begin
            nticks++;
            `CHK(seg_t, seg_of(word))
            `CHK(seg_c, ~seg_t)
            if (chk_en && ($time - t_rise < 203)) begin
                `CHK(word, prev.second_port_bits)
            end else if (chk_en) begin
                `CHK(word, cur.first_port_bits)
            end
        end
    end

    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            wrap_up();
        end
    end

    initial begin
        step(6);
        i_rst_n = 1'b1;
        step(1);
        `CHK(rdiv, 4'h1)
        `CHK(seg_c, {47{1'b1}})
        `CHK(lock, 1'b0)
        run = 1'b1;
        step(200);
        `CHK(nticks, 0)
        `CHK(lock, 1'b0)
        sup = 1'b1;
        step(90);
        chk_en = 1;
        @(posedge ext_clk);
        k = nticks;
        repeat (10) @(posedge ext_clk);
        `CHK(nticks - k, 20)
        step(100);
        `CHK(lock, 1'b1)
        chk_en = 0;
        for (int s = 0; s < 4; s++) begin
            {shi, slo} = 2'(s);
            step(10);
            `CHK(rdiv, 4'h1 << s)
            // Skip the period in which the select changed and the period after it
            repeat (2) @(posedge ext_clk);
            k = nticks;
            repeat (4) @(posedge ext_clk);
            `CHK(nticks - k, 8)
            step(1);
        end
        {shi, slo} = 2'b00;
        step(10);
        sup = 1'b0;
        step(10);
        `CHK(lock, 1'b0)
        k = nticks;
        step(100);
        `CHK(nticks - k, 0)
        wrap_up();
    end
endmodule
